// ==== chan_supervisor.sv ====
// shared constants and types, plus the per-channel threshold and min/max supervisor
`timescale 1ns/1ps

package adc_limit_pkg;
	localparam int NUM_CH = 4;
	localparam int DATA_W = 16;
	localparam int VAL_W  = 12;
	localparam int STAT_W = 2 * NUM_CH;

	// register pointer values
	localparam logic [3:0] ADDR_RESULT     = 4'h0;
	localparam logic [3:0] ADDR_ALERT      = 4'h1;
	localparam logic [3:0] ADDR_CONFIG     = 4'h2;
	localparam logic [3:0] ADDR_LIMIT_BASE = 4'h4;
	localparam logic [3:0] LIMIT_STRIDE    = 4'h3;
	localparam logic [3:0] KIND_LOWER      = 4'h0;
	localparam logic [3:0] KIND_UPPER      = 4'h1;
	localparam logic [3:0] KIND_HYST       = 4'h2;

	// result and config word layout
	localparam int RES_FLAG_BIT = 15;
	localparam int RES_ZERO_BIT = 14;
	localparam int RES_TAG_LSB  = 12;
	localparam int CFG_FN_LSB   = 1;

	typedef enum logic [1:0] {
		FN_NONE  = 2'h0,
		FN_BUSY  = 2'h1,
		FN_ALERT = 2'h2,
		FN_CLEAR = 2'h3
	} alert_fn_e;

	localparam logic [1:0]        CFG_FN_RESET    = 2'h0;
	localparam logic [7:0]        ALERT_CLEAR_ALL = 8'hff;
	localparam logic [VAL_W-1:0]  FULL_SCALE_12   = 12'hfff;
	localparam logic [VAL_W-1:0]  FULL_SCALE_10   = 12'hffc;
	localparam logic [VAL_W-1:0]  ZERO_SCALE      = 12'h000;
	localparam logic [VAL_W-1:0]  HYST_RESET_12   = 12'h008;
	localparam logic [VAL_W-1:0]  HYST_RESET_10   = 12'h002;
	localparam logic [VAL_W-1:0]  MINMAX_CODE     = 12'hfff;

	typedef struct packed {
		logic             valid;
		logic [1:0]       chan;
		logic [VAL_W-1:0] value;
	} conv_s;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [3:0]        addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_s;
endpackage

module chan_supervisor
	import adc_limit_pkg::*;
#(
	parameter int RES_BITS = 12
)(
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire logic             conv_hit,
	input  wire logic [VAL_W-1:0] conv_value,
	input  wire logic             wr_lower,
	input  wire logic             wr_upper,
	input  wire logic             wr_hyst,
	input  wire logic [VAL_W-1:0] wdata,
	input  wire logic             clear_all,
	output logic      [VAL_W-1:0] upper_q,
	output logic      [VAL_W-1:0] lower_q,
	output logic      [VAL_W-1:0] hyst_q,
	output logic                  over_q,
	output logic                  under_q,
	output logic                  minmax
);
	localparam logic [VAL_W-1:0] FULL_SCALE = (RES_BITS == 12) ? FULL_SCALE_12 : FULL_SCALE_10;
	localparam logic [VAL_W-1:0] HYST_INIT  = (RES_BITS == 12) ? HYST_RESET_12 : HYST_RESET_10;

	generate
		if (RES_BITS != 12 && RES_BITS != 10)
		begin : g_bad_res
			$error("RES_BITS must be 10 or 12");
		end
	endgenerate

	logic [VAL_W-1:0] upper_d;
	logic [VAL_W-1:0] lower_d;
	logic [VAL_W-1:0] hyst_d;
	logic             over_d;
	logic             under_d;
	logic             over_rel;
	logic             under_rel;

	// RQ17 min/max mode
	assign minmax = (hyst_q == MINMAX_CODE);
	// RQ10 upper release point
	// 13-bit sums so a threshold below N never wraps into a false release
	assign over_rel = ({1'b0, conv_value} + {1'b0, hyst_q}) <= {1'b0, upper_q};
	// RQ12 lower release point
	assign under_rel = {1'b0, conv_value} >= ({1'b0, lower_q} + {1'b0, hyst_q});

	always_comb
	begin
		upper_d = wr_upper ? wdata : upper_q;
		lower_d = wr_lower ? wdata : lower_q;
		hyst_d  = wr_hyst ? wdata : hyst_q;
		over_d  = over_q;
		under_d = under_q;
		if (clear_all)
		begin
			over_d  = 1'b0;
			under_d = 1'b0;
		end
		if (conv_hit && minmax)
		begin
			// RQ21 track extremes
			if (conv_value > upper_q)
				upper_d = conv_value;
			if (conv_value < lower_q)
				lower_d = conv_value;
		end
		else if (conv_hit)
		begin
			// RQ9 strict over test
			// a new violation beats a clear in the same cycle
			if (conv_value > upper_q)
				over_d = 1'b1;
			else if (over_rel)
				over_d = 1'b0;
			// RQ11 strict under test
			if (conv_value < lower_q)
				under_d = 1'b1;
			else if (under_rel)
				under_d = 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			// RQ14 full and zero scale
			upper_q <= FULL_SCALE;
			lower_q <= ZERO_SCALE;
			// RQ15 hysteresis default
			hyst_q  <= HYST_INIT;
			over_q  <= 1'b0;
			under_q <= 1'b0;
		end
		else
		begin
			upper_q <= upper_d;
			lower_q <= lower_d;
			hyst_q  <= hyst_d;
			over_q  <= over_d;
			under_q <= under_d;
		end
	end
endmodule

// ==== adc_result_limit_alert.sv ====
// result formatting, limit supervision and alert/busy pin for a four-input converter
`timescale 1ns/1ps

// Operation
// RQ1: function field picks none, busy, alert
// RQ2: writing ones clears pin, flag, status
// RQ3: clear command reads back as alert mode
// RQ4: sixteen-bit result, high byte read first
// RQ5: flag, zero, tag, value bit layout
// RQ6: channel tag is index minus one
// RQ7: ten-bit variant zeros two low bits
// RQ8: flag shows any channel's violation
// RQ9: over alert when result exceeds upper
// RQ10: over clears N below upper threshold
// RQ11: under alert when result below lower
// RQ12: under clears N above lower threshold
// RQ13: limit registers twelve bits, top zero
// RQ14: reset upper full, lower zero scale
// RQ15: hysteresis resets to eight or two
// RQ16: four sets of three channel registers
// RQ17: hysteresis all ones selects min/max
// RQ18: violation shown on pin, flag, both
// RQ19: status holds under/over bit per channel
// RQ20: writing all ones clears status register
// RQ21: min/max replaces on greater or smaller
module adc_result_limit_alert
	import adc_limit_pkg::*;
#(
	parameter int RES_BITS = 12
)(
	input  wire logic              mclk,
	input  wire logic              srst,
	input  wire conv_s             conv_data,
	input  wire logic              conv_busy,
	input  wire reg_req_s          reg_req,
	output logic      [DATA_W-1:0] rdata_q,
	output logic                   rvalid_q,
	output logic                   alert_out_q
);
	localparam logic [VAL_W-1:0] RES_MASK = (RES_BITS == 12) ? FULL_SCALE_12 : FULL_SCALE_10;

	generate
		if (RES_BITS != 12 && RES_BITS != 10)
		begin : g_bad_res
			$error("RES_BITS must be 10 or 12");
		end
	endgenerate

	logic [NUM_CH-1:0] conv_hit;
	logic [NUM_CH-1:0] wr_lo;
	logic [NUM_CH-1:0] wr_up;
	logic [NUM_CH-1:0] wr_hy;
	logic [NUM_CH-1:0] over;
	logic [NUM_CH-1:0] under;
	logic [NUM_CH-1:0] minmax;
	logic [VAL_W-1:0]  upper [NUM_CH];
	logic [VAL_W-1:0]  lower [NUM_CH];
	logic [VAL_W-1:0]  hyst  [NUM_CH];
	logic [STAT_W-1:0] alert_status;
	logic [VAL_W-1:0]  value_masked;
	logic              cfg_wr;
	logic              alert_wr;
	logic              clear_all;
	logic [3:0]        lim_off;
	logic [1:0]        lim_ch;
	logic [3:0]        lim_kind;

	logic [13:0]       result_q;
	logic [13:0]       result_d;
	logic [1:0]        cfg_fn_q;
	logic [1:0]        cfg_fn_d;
	logic              alert_out_d;
	logic [DATA_W-1:0] rdata_d;
	logic              rvalid_d;

	// RQ7 trailing zeros
	assign value_masked = conv_data.value & RES_MASK;
	assign cfg_wr       = reg_req.wr && (reg_req.addr == ADDR_CONFIG);
	assign alert_wr     = reg_req.wr && (reg_req.addr == ADDR_ALERT);
	// RQ2 clear by function field
	// RQ20 clear by all ones
	assign clear_all = (cfg_wr && (reg_req.wdata[CFG_FN_LSB +: 2] == FN_CLEAR))
		|| (alert_wr && (reg_req.wdata[7:0] == ALERT_CLEAR_ALL));

	// RQ16 four channel sets
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++)
		begin : g_ch
			localparam logic [3:0] A_LO = 4'(ADDR_LIMIT_BASE + LIMIT_STRIDE * c);
			assign conv_hit[c] = conv_data.valid && (conv_data.chan == 2'(c));
			assign wr_lo[c]    = reg_req.wr && (reg_req.addr == A_LO + KIND_LOWER);
			assign wr_up[c]    = reg_req.wr && (reg_req.addr == A_LO + KIND_UPPER);
			assign wr_hy[c]    = reg_req.wr && (reg_req.addr == A_LO + KIND_HYST);
			// RQ19 status bit order
			assign alert_status[2*c]   = under[c];
			assign alert_status[2*c+1] = over[c];

			chan_supervisor #(
				.RES_BITS (RES_BITS)
			) u_chan (
				.mclk       (mclk),
				.srst       (srst),
				.conv_hit   (conv_hit[c]),
				.conv_value (value_masked),
				.wr_lower   (wr_lo[c]),
				.wr_upper   (wr_up[c]),
				.wr_hyst    (wr_hy[c]),
				.wdata      (reg_req.wdata[VAL_W-1:0]),
				.clear_all  (clear_all),
				.upper_q    (upper[c]),
				.lower_q    (lower[c]),
				.hyst_q     (hyst[c]),
				.over_q     (over[c]),
				.under_q    (under[c]),
				.minmax     (minmax[c])
			);
		end
	endgenerate

	assign lim_off  = reg_req.addr - ADDR_LIMIT_BASE;
	assign lim_ch   = 2'(lim_off / LIMIT_STRIDE);
	assign lim_kind = lim_off % LIMIT_STRIDE;

	always_comb
	begin
		result_d = result_q;
		// RQ6 tag from index
		if (conv_data.valid)
			result_d = {conv_data.chan, value_masked};
		cfg_fn_d = cfg_fn_q;
		if (cfg_wr)
		begin
			// RQ3 clear reads back alert
			if (reg_req.wdata[CFG_FN_LSB +: 2] == FN_CLEAR)
				cfg_fn_d = FN_ALERT;
			else
				cfg_fn_d = reg_req.wdata[CFG_FN_LSB +: 2];
		end
	end

	// RQ1 pin function select
	// RQ18 pin follows alert mode
	// one cycle behind the status bits so the pin stays a clean flop output
	always_comb
	begin
		case (cfg_fn_q)
			FN_NONE:  alert_out_d = 1'b0;
			FN_BUSY:  alert_out_d = conv_busy;
			FN_ALERT: alert_out_d = |alert_status;
			default:  alert_out_d = 1'b0;
		endcase
	end

	// whole word captured at once so both bytes come from one result
	always_comb
	begin
		rvalid_d = reg_req.rd;
		rdata_d  = '0;
		if (reg_req.rd)
		begin
			if (reg_req.addr == ADDR_RESULT)
				// RQ4 word snapshot
				// RQ5 result layout
				// RQ8 flag from any channel
				rdata_d = {|alert_status, 1'b0, result_q};
			else if (reg_req.addr == ADDR_ALERT)
				rdata_d = {8'h00, alert_status};
			else if (reg_req.addr == ADDR_CONFIG)
				rdata_d = {13'h0000, cfg_fn_q, 1'b0};
			else if (reg_req.addr >= ADDR_LIMIT_BASE)
			begin
				// RQ13 top nibble zero
				case (lim_kind)
					KIND_LOWER: rdata_d = {4'h0, lower[lim_ch]};
					KIND_UPPER: rdata_d = {4'h0, upper[lim_ch]};
					KIND_HYST:  rdata_d = {4'h0, hyst[lim_ch]};
					default:    rdata_d = '0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			result_q    <= '0;
			cfg_fn_q    <= CFG_FN_RESET;
			alert_out_q <= 1'b0;
			rdata_q     <= '0;
			rvalid_q    <= 1'b0;
		end
		else
		begin
			result_q    <= result_d;
			cfg_fn_q    <= cfg_fn_d;
			alert_out_q <= alert_out_d;
			rdata_q     <= rdata_d;
			rvalid_q    <= rvalid_d;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	logic       hit_over;
	logic       hit_under;
	logic [1:0] ch;
	assign ch        = conv_data.chan;
	assign hit_over  = conv_data.valid && !minmax[ch] && (value_masked > upper[ch]);
	assign hit_under = conv_data.valid && !minmax[ch] && (value_masked < lower[ch]);

	property p_fn_none;
		cfg_fn_q == FN_NONE ##1 cfg_fn_q == FN_NONE |-> !alert_out_q;
	endproperty
	a_fn_none: assert property (p_fn_none) else $error("pin active in none mode"); // RQ1

	property p_fn_busy;
		cfg_fn_q == FN_BUSY |=> alert_out_q == $past(conv_busy) || $past(cfg_fn_q) != FN_BUSY;
	endproperty
	a_fn_busy: assert property (p_fn_busy) else $error("busy pin mismatch"); // RQ1

	property p_clear_all;
		clear_all && !conv_data.valid
			|=> alert_status == '0 ##1 (cfg_fn_q != FN_ALERT || !alert_out_q || |alert_status);
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("clear left alerts"); // RQ2

	property p_clear_readback;
		cfg_wr && reg_req.wdata[CFG_FN_LSB +: 2] == FN_CLEAR |=> cfg_fn_q == FN_ALERT;
	endproperty
	a_clear_readback: assert property (p_clear_readback) else $error("clear readback wrong"); // RQ3

	property p_result_word;
		reg_req.rd && reg_req.addr == ADDR_RESULT
			|=> !rdata_q[RES_ZERO_BIT] && rdata_q[RES_FLAG_BIT] == $past(|alert_status);
	endproperty
	a_result_word: assert property (p_result_word) else $error("result flag or zero bit wrong"); // RQ8

	property p_tag;
		conv_data.valid |=> result_q[13:12] == $past(conv_data.chan);
	endproperty
	a_tag: assert property (p_tag) else $error("channel tag wrong"); // RQ6

	// fires on every result so the low-bit mask is exercised in either variant
	property p_low_zero;
		conv_data.valid |=> result_q[1:0] == ($past(conv_data.value[1:0]) & RES_MASK[1:0]);
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("ten-bit low bits set"); // RQ7

	property p_over_set;
		hit_over |=> alert_status[{$past(ch), 1'b1}];
	endproperty
	a_over_set: assert property (p_over_set) else $error("over alert missed"); // RQ9

	property p_under_set;
		hit_under |=> alert_status[{$past(ch), 1'b0}];
	endproperty
	a_under_set: assert property (p_under_set) else $error("under alert missed"); // RQ11

	property p_status_clear;
		alert_wr && reg_req.wdata[7:0] == ALERT_CLEAR_ALL && !conv_data.valid
			|=> alert_status == '0;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status not cleared"); // RQ20

	property p_pin_alert;
		cfg_fn_q == FN_ALERT |=> alert_out_q == $past(|alert_status);
	endproperty
	a_pin_alert: assert property (p_pin_alert) else $error("pin not following status"); // RQ18

	property p_read_pulse;
		reg_req.rd |=> rvalid_q;
	endproperty
	a_read_pulse: assert property (p_read_pulse) else $error("read not answered"); // RQ4

	property p_read_idle;
		!reg_req.rd |=> !rvalid_q && rdata_q == '0;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data without a read"); // RQ4

	property p_top_zero;
		reg_req.rd && reg_req.addr >= ADDR_LIMIT_BASE |=> rdata_q[15:12] == 4'h0;
	endproperty
	a_top_zero: assert property (p_top_zero) else $error("limit top nibble set"); // RQ13

	property p_minmax_quiet;
		conv_data.valid && minmax[ch] && !clear_all |=> alert_status == $past(alert_status);
	endproperty
	a_minmax_quiet: assert property (p_minmax_quiet) else $error("min/max channel alerted"); // RQ17

	property p_max_track;
		conv_data.valid && minmax[ch] && value_masked > upper[ch]
			|=> upper[$past(ch)] == $past(value_masked);
	endproperty
	a_max_track: assert property (p_max_track) else $error("maximum not stored"); // RQ21

	property p_min_track;
		conv_data.valid && minmax[ch] && value_masked < lower[ch]
			|=> lower[$past(ch)] == $past(value_masked);
	endproperty
	a_min_track: assert property (p_min_track) else $error("minimum not stored"); // RQ21

	c_alert_pin: cover property (cfg_fn_q == FN_ALERT ##1 alert_out_q);
	c_clear:     cover property (|alert_status ##1 clear_all ##1 alert_status == '0);
	c_minmax:    cover property (conv_data.valid && minmax[ch] && value_masked > upper[ch]);
	c_busy:      cover property (cfg_fn_q == FN_BUSY && alert_out_q);
endmodule

// ==== host_model.sv ====
// register-bus host model: single word writes and reads, high byte taken first
`timescale 1ns/1ps

module host_model
	import adc_limit_pkg::*;
(
	input  wire logic              mclk,
	output reg_req_s               reg_req,
	input  wire logic [DATA_W-1:0] rdata_q,
	input  wire logic              rvalid_q
);
	initial reg_req = '{1'b0, 1'b0, 4'h0, 16'h0000};

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(negedge mclk);
		reg_req.wr    <= 1'b1;
		reg_req.addr  <= a;
		reg_req.wdata <= d;
		@(negedge mclk);
		reg_req.wr    <= 1'b0;
		reg_req.addr  <= ~a;
		reg_req.wdata <= ~d;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		logic [7:0] hi;
		logic [7:0] lo;
		int         n;
		@(negedge mclk);
		reg_req.rd   <= 1'b1;
		reg_req.addr <= a;
		@(negedge mclk);
		reg_req.rd   <= 1'b0;
		reg_req.addr <= ~a;
		n = 0;
		while (rvalid_q !== 1'b1 && n < 8)
		begin
			@(negedge mclk);
			n++;
		end
		hi = (n < 8) ? rdata_q[15:8] : 8'hxx;
		lo = (n < 8) ? rdata_q[7:0] : 8'hxx;
		d = {hi, lo};
	endtask
endmodule

// ==== adc_result_limit_alert_tb.sv ====
// self-checking bench with a behavioural limit and status model
`timescale 1ns/1ps

module adc_result_limit_alert_tb
	import adc_limit_pkg::*;
;
	logic              mclk = 1'b0;
	logic              srst = 1'b1;
	conv_s             conv_data = '0;
	logic              conv_busy = 1'b0;
	reg_req_s          reg_req;
	logic [DATA_W-1:0] rdata_q;
	logic              rvalid_q;
	logic              alert_out_q;
	int                error_cnt = 0;
	int                comparisons = 0;
	int unsigned       seed = 71;
	int                lim_m [4][3];
	logic [7:0]        st = 8'h00;
	int                fn = 0;
	logic [15:0]       w;
	int                ch;
	int                b;
	int                seq [10] = '{'h0801, 'h07fd, 'h07fc, 'h0800, 'h10ff,
		'h1107, 'h1108, 'h1100, 'h0fff, 'h3123};

	always #10 mclk = ~mclk;

	adc_result_limit_alert #(.RES_BITS(12)) i_adc_result_limit_alert (
		.mclk       (mclk),
		.srst       (srst),
		.conv_data  (conv_data),
		.conv_busy  (conv_busy),
		.reg_req    (reg_req),
		.rdata_q    (rdata_q),
		.rvalid_q   (rvalid_q),
		.alert_out_q(alert_out_q)
	);

	host_model i_host_model (
		.mclk    (mclk),
		.reg_req (reg_req),
		.rdata_q (rdata_q),
		.rvalid_q(rvalid_q)
	);

	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic lim(input int c, input int k, input int v);
		logic [3:0] spare_bits;
		// random upper nibble must be dropped
		spare_bits = 4'(rnd());
		i_host_model.wr_reg(ADDR_LIMIT_BASE + LIMIT_STRIDE * 4'(c) + 4'(k), {spare_bits, 12'(v)});
		lim_m[c][k] = v;
	endtask

	task automatic conv(input int c, input int v);
		logic [15:0] r;
		@(negedge mclk);
		conv_data <= '{1'b1, 2'(c), 12'(v)};
		@(negedge mclk);
		conv_data.valid <= 1'b0;
		conv_data.value <= ~12'(v);
		if (lim_m[c][KIND_HYST] == MINMAX_CODE)
		begin
			if (v > lim_m[c][KIND_UPPER]) lim_m[c][KIND_UPPER] = v;
			if (v < lim_m[c][KIND_LOWER]) lim_m[c][KIND_LOWER] = v;
		end
		else
		begin
			if (v > lim_m[c][KIND_UPPER]) st[2*c+1] = 1'b1;
			else if (v + lim_m[c][KIND_HYST] <= lim_m[c][KIND_UPPER]) st[2*c+1] = 1'b0;
			if (v < lim_m[c][KIND_LOWER]) st[2*c] = 1'b1;
			else if (v >= lim_m[c][KIND_LOWER] + lim_m[c][KIND_HYST]) st[2*c] = 1'b0;
		end
		@(negedge mclk);
		chk({15'h0000, alert_out_q}, {15'h0000, fn == 2 && st != 0});
		i_host_model.rd_reg(ADDR_RESULT, r);
		chk(r, {st != 0, 1'b0, 2'(c), 12'(v)});
	endtask

	task automatic check_all();
		for (int c = 0; c < 4; c++)
			for (int k = 0; k < 3; k++)
			begin
				i_host_model.rd_reg(ADDR_LIMIT_BASE + LIMIT_STRIDE * 4'(c) + 4'(k), w);
				chk(w, 16'(lim_m[c][k]));
			end
		i_host_model.rd_reg(ADDR_ALERT, w);
		chk(w, {8'h00, st});
		i_host_model.rd_reg(ADDR_CONFIG, w);
		chk(w, 16'(fn << CFG_FN_LSB));
		i_host_model.rd_reg(4'h3, w);
		chk(w, 16'h0000);
		chk({15'h0000, alert_out_q}, {15'h0000, fn == 2 && st != 0});
	endtask

	task automatic end_sim();
		$display("comparisons %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		#400000;
		error_cnt++;
		end_sim();
	end

	initial
	begin
		for (int c = 0; c < 4; c++)
			lim_m[c] = '{ZERO_SCALE, FULL_SCALE_12, HYST_RESET_12};
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		srst <= 1'b0;
		check_all();
		i_host_model.wr_reg(ADDR_CONFIG, 16'h0004);
		fn = 2;
		i_host_model.wr_reg(ADDR_RESULT, 16'hffff);
		i_host_model.rd_reg(ADDR_RESULT, w);
		chk(w, 16'h0000);
		i_host_model.wr_reg(4'h3, 16'h0fff);
		lim(0, KIND_UPPER, 'h800);
		lim(0, KIND_HYST, 4);
		lim(1, KIND_LOWER, 'h100);
		foreach (seq[i])
			conv(seq[i] >> 12, seq[i] & 'hfff);
		check_all();
		// clear through the function field
		i_host_model.wr_reg(ADDR_CONFIG, 16'h0006);
		st = 8'h00;
		check_all();
		lim(2, KIND_UPPER, 0);
		lim(2, KIND_LOWER, 'hfff);
		lim(2, KIND_HYST, MINMAX_CODE);
		lim(3, KIND_HYST, rnd() % 16);
		repeat (40)
		begin
			ch = rnd() % 4;
			if (rnd() % 4 == 0 && ch != 2)
				lim(ch, rnd() % 2, rnd() % 4096);
			conv(ch, rnd() % 4096);
		end
		check_all();
		conv(0, 'hfff);
		i_host_model.wr_reg(ADDR_ALERT, {8'h00, ALERT_CLEAR_ALL});
		st = 8'h00;
		check_all();
		i_host_model.wr_reg(ADDR_CONFIG, 16'h0002);
		fn = 1;
		repeat (16)
		begin
			@(negedge mclk);
			b = rnd() % 2;
			conv_busy <= 1'(b);
			@(negedge mclk);
			chk({15'h0000, alert_out_q}, 16'(b));
		end
		i_host_model.wr_reg(ADDR_CONFIG, 16'h0000);
		fn = 0;
		conv(0, 'hfff);
		check_all();
		end_sim();
	end
endmodule
